/* hdl/modbus_slave.sv */
// modbus_slave: rtu slave frame handler with ahb-lite setup registers
// assumes a uart outside handing bytes in and out on clk, and a register
// store answering regRdAddr with regRdData in the same cycle
`timescale 1ns/1ps
`default_nettype none
module modbus_slave import modbus_pkg::*; #(
  parameter int GAP_LEN = GAP_CYCLES,
  parameter int MS_LEN = MS_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic [7:0] txByte,
  output logic txValid,
  input wire logic txReady,
  output logic rtsOut,
  output logic [1:0] parityMode,
  output logic commFault,
  output logic regWrEn,
  output logic [15:0] regWrAddr,
  output logic [15:0] regWrData,
  output logic [15:0] regRdAddr,
  input wire logic [15:0] regRdData
);
  state_t st_q, st_d;
  logic [5:0] station_q;
  logic [1:0] parity_q;
  logic tmoEn_q, rtsCtl_q;
  logic [6:0] delay_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] hrdata_q;
  logic [15:0] frames_q;
  logic [7:0] rxBuf_q [0:40];
  logic [5:0] rxCnt_q, txLen_q, txIdx_q;
  logic ovf_q, bcast_q, rts_q, regWrEn_q;
  logic [7:0] excCode_q, txByte_q;
  logic [4:0] wIdx_q;
  logic [15:0] regWrAddr_q, regWrData_q, regRdAddr_q;

  // ahb-lite slave, zero wait states, always okay
  wire logic accept = hsel && hready && htrans[1];
  wire logic cfgWr = wrPend_q && (wrAddr_q == CFG_OFS);
  wire logic [31:0] cfgWord = ({26'h0, station_q} << STATION_LSB) | ({30'h0, parity_q} << PARITY_LSB)
    | ({31'h0, tmoEn_q} << TMO_EN_BIT) | ({31'h0, rtsCtl_q} << RTS_CTL_BIT) | ({25'h0, delay_q} << DELAY_LSB);
  wire logic [31:0] statWord = {frames_q, excCode_q, 6'h00, (st_q != IDLE), commFault};
  wire logic [31:0] rdMux = (haddr[7:0] == CFG_OFS) ? cfgWord : (haddr[7:0] == STAT_OFS) ? statWord : 32'h0000_0000;
  wire logic [5:0] newStation = hwdata[STATION_LSB +: 6];
  wire logic [1:0] newParity = hwdata[PARITY_LSB +: 2];
  wire logic [6:0] newDelay = hwdata[DELAY_LSB +: 7];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wrPend_q <= accept && hwrite;
      wrAddr_q <= haddr[7:0];
      hrdata_q <= (accept && !hwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // out-of-range settings are ignored rather than clipped
  always_ff @(posedge clk) begin
    if (!resetn) begin
      station_q <= STATION_RST;
      parity_q <= PARITY_RST;
      tmoEn_q <= 1'b1;
      rtsCtl_q <= 1'b1;
      delay_q <= DELAY_RST;
    end else if (cfgWr) begin
      if (newStation <= STATION_MAX) begin
        station_q <= newStation;
      end
      if (newParity != PARITY_BAD) begin
        parity_q <= newParity;
      end
      if (newDelay >= DELAY_MIN && newDelay <= DELAY_MAX) begin
        delay_q <= newDelay;
      end
      tmoEn_q <= hwdata[TMO_EN_BIT];
      rtsCtl_q <= hwdata[RTS_CTL_BIT];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign parityMode = parity_q;

  // frame decode
  wire logic [7:0] fn = rxBuf_q[1];
  wire logic [15:0] startAddr = {rxBuf_q[2], rxBuf_q[3]};
  wire logic [15:0] qty = {rxBuf_q[4], rxBuf_q[5]};
  wire logic [7:0] byteCnt = rxBuf_q[6];
  wire logic [15:0] crcRx, crcTx;
  wire logic isRead = fn == FN_READ;
  wire logic isLoop = fn == FN_LOOP;
  wire logic isWrite = fn == FN_WRITE;
  wire logic qtyOk = (qty != 16'h0000) && (qty <= QTY_MAX);
  wire logic lenOk = isWrite ? (rxCnt_q >= LEN_WR_MIN && {2'b00, rxCnt_q} == byteCnt + WR_HDR)
    : (rxCnt_q == LEN_FIXED);
  wire logic cntOk = !isWrite || (byteCnt == {qty[6:0], 1'b0});
  wire logic [7:0] excCode = !(isRead || isLoop || isWrite) ? EXC_FUNC
    : (!lenOk || !cntOk || (!isLoop && !qtyOk)) ? EXC_DATA : EXC_NONE;
  wire logic isBcast = rxBuf_q[0] == BCAST_ADDR;
  wire logic addrHit = isBcast || (station_q != 6'h00 && rxBuf_q[0] == {2'b00, station_q});
  // a residue of zero over data plus check bytes means the check matched
  wire logic frameOk = !ovf_q && rxCnt_q >= LEN_MIN && crcRx == 16'h0000 && addrHit;
  wire logic validFrame = (st_q == CHECK) && frameOk;
  wire logic [5:0] txLen = (excCode != EXC_NONE) ? LEN_EXC : isRead ? RD_HDR + {qty[4:0], 1'b0} : LEN_FIXED;
  wire logic gapDone, msTick, tmoDone, delayDone;
  wire logic frameEnd = (st_q == IDLE) && gapDone && (rxCnt_q != 6'h00) && !rxValid;
  wire logic lastWord = {11'h000, wIdx_q} == qty - 16'h0001;
  wire logic txDone = txValid && txReady && (txIdx_q == txLen_q - 6'h01);
  wire logic [5:0] dataIdx = txIdx_q - 6'h03;
  wire logic [5:0] wrIdx = 6'h07 + {wIdx_q, 1'b0};
  wire logic crcLoSel = txIdx_q == txLen_q - 6'h02;
  wire logic crcHiSel = txIdx_q == txLen_q - 6'h01;
  logic [7:0] byteSel;

  always_comb begin
    if (crcLoSel) begin
      byteSel = crcTx[7:0];
    end else if (crcHiSel) begin
      byteSel = crcTx[15:8];
    end else if (excCode_q != EXC_NONE) begin
      byteSel = (txIdx_q == 6'h00) ? rxBuf_q[0] : (txIdx_q == 6'h01) ? (fn | EXC_FLAG) : excCode_q;
    end else if (isRead && txIdx_q >= 6'h03) begin
      byteSel = dataIdx[0] ? regRdData[7:0] : regRdData[15:8];
    end else if (isRead && txIdx_q == 6'h02) begin
      byteSel = {qty[6:0], 1'b0};
    end else begin
      byteSel = rxBuf_q[txIdx_q[2:0]];
    end
  end

  always_comb begin
    case (st_q)
      IDLE: st_d = frameEnd ? CHECK : IDLE;
      CHECK: begin
        if (!frameOk) begin
          st_d = IDLE;
        end else if (excCode == EXC_NONE && isWrite) begin
          st_d = EXEC;
        end else begin
          st_d = isBcast ? IDLE : WAIT;
        end
      end
      EXEC: st_d = !lastWord ? EXEC : bcast_q ? IDLE : WAIT;
      WAIT: st_d = delayDone ? PREP : WAIT;
      PREP: st_d = LOAD;
      LOAD: st_d = SEND;
      SEND: st_d = !(txValid && txReady) ? SEND : txDone ? IDLE : PREP;
      default: st_d = IDLE;
    endcase
  end

  // receive: bytes taken only while idle, the link is half duplex
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= IDLE;
      rxCnt_q <= 6'h00;
      ovf_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == CHECK) begin
        rxCnt_q <= 6'h00;
        ovf_q <= 1'b0;
      end else if (st_q == IDLE && rxValid) begin
        if (rxCnt_q == LEN_MAX) begin
          ovf_q <= 1'b1;
        end else begin
          rxCnt_q <= rxCnt_q + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (st_q == IDLE && rxValid && rxCnt_q != LEN_MAX) begin
      rxBuf_q[rxCnt_q] <= rxByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      excCode_q <= EXC_NONE;
      bcast_q <= 1'b0;
      txLen_q <= LEN_FIXED;
      frames_q <= 16'h0000;
    end else if (validFrame) begin
      excCode_q <= excCode;
      bcast_q <= isBcast;
      txLen_q <= txLen;
      frames_q <= frames_q + 16'h0001;
    end
  end

  // write walk: one word per cycle, ascending addresses
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wIdx_q <= 5'h00;
      regWrEn_q <= 1'b0;
      regWrAddr_q <= 16'h0000;
      regWrData_q <= 16'h0000;
    end else begin
      wIdx_q <= (st_q == EXEC) ? wIdx_q + 5'h01 : 5'h00;
      regWrEn_q <= st_q == EXEC;
      regWrAddr_q <= startAddr + {11'h000, wIdx_q};
      regWrData_q <= {rxBuf_q[wrIdx], rxBuf_q[wrIdx + 6'h01]};
    end
  end

  // transmit walk: prep sets the read address, load latches the byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txIdx_q <= 6'h00;
      txByte_q <= 8'h00;
      regRdAddr_q <= 16'h0000;
      rts_q <= 1'b0;
    end else begin
      if (st_q == WAIT) begin
        txIdx_q <= 6'h00;
      end else if (st_q == SEND && txValid && txReady) begin
        txIdx_q <= txIdx_q + 6'h01;
      end
      if (st_q == PREP) begin
        regRdAddr_q <= startAddr + {11'h000, dataIdx[5:1]};
      end
      if (st_q == LOAD) begin
        txByte_q <= byteSel;
      end
      rts_q <= !rtsCtl_q || st_d == PREP || st_d == LOAD || st_d == SEND;
    end
  end

  assign txValid = st_q == SEND;
  assign txByte = txByte_q;
  assign rtsOut = rts_q;
  assign regWrEn = regWrEn_q;
  assign regWrAddr = regWrAddr_q;
  assign regWrData = regWrData_q;
  assign regRdAddr = regRdAddr_q;
  // gated so that clearing the enable drops the fault in the same cycle
  assign commFault = tmoDone && tmoEn_q;

  crc16_unit rxCrc (
    .clk(clk),
    .resetn(resetn),
    .init(st_q != IDLE),
    .en(st_q == IDLE && rxValid),
    .data(rxByte),
    .crc(crcRx)
  );

  crc16_unit txCrc (
    .clk(clk),
    .resetn(resetn),
    .init(st_q == WAIT),
    .en(txValid && txReady && !crcLoSel && !crcHiSel),
    .data(txByte_q),
    .crc(crcTx)
  );

  tick_timer #(.W(20)) gapTimer (
    .clk(clk),
    .resetn(resetn),
    .clr(rxValid),
    .en(1'b1),
    .limit(20'(GAP_LEN)),
    .done(gapDone)
  );

  // prescaler restarts at check so the reply delay is never a tick short
  tick_timer #(.W(17)) msTimer (
    .clk(clk),
    .resetn(resetn),
    .clr(msTick || st_q == CHECK),
    .en(1'b1),
    .limit(17'(MS_LEN - 1)),
    .done(msTick)
  );

  tick_timer #(.W(12)) tmoTimer (
    .clk(clk),
    .resetn(resetn),
    .clr(validFrame || !tmoEn_q),
    .en(msTick),
    .limit(12'(TIMEOUT_MS + 1)),
    .done(tmoDone)
  );

  tick_timer #(.W(7)) delayTimer (
    .clk(clk),
    .resetn(resetn),
    .clr(st_q != WAIT),
    .en(msTick),
    .limit(delay_q),
    .done(delayDone)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rts_level_a: assert property ((!rtsCtl_q && !$past(rtsCtl_q) || txValid) |-> rtsOut) else $error("send request low");
  bcast_silent_a: assert property (validFrame && isBcast |=> st_q != WAIT) else $error("broadcast answered");
  tx_len_a: assert property (txValid |-> txLen_q >= LEN_EXC && txLen_q <= 6'h25) else $error("bad reply length");
  wr_exec_a: assert property (regWrEn |-> $past(st_q) == EXEC) else $error("stray register write");
  bad_drop_a: assert property (st_q == CHECK && !frameOk |=> st_q == IDLE) else $error("bad frame kept");
  exc_flag_a: assert property (txValid && txIdx_q == 6'h01 && excCode_q != EXC_NONE |-> txByte[7])
    else $error("error reply without flag");
  crc_low_a: assert property (txValid && crcLoSel |-> txByte == crcTx[7:0]) else $error("crc low byte wrong");
  station_rng_a: assert property (station_q <= STATION_MAX) else $error("station out of range");
  parity_enc_a: assert property (parityMode != PARITY_BAD) else $error("bad parity code");
  delay_gate_a: assert property (st_q == WAIT ##1 st_q == PREP |-> $past(delayDone)) else $error("reply too early");
  fault_gate_a: assert property (commFault |-> tmoEn_q) else $error("fault while disabled");

  read_reply_c: cover property (txDone && isRead && excCode_q == EXC_NONE);
  write_exec_c: cover property (st_q == EXEC && lastWord);
  error_reply_c: cover property (txDone && excCode_q != EXC_NONE);
endmodule
`default_nettype wire

/* hdl/modbus_pkg.sv */
// modbus_pkg: constants for the serial slave frame handler
// assumes a byte-wide uart on the same clock and an ahb-lite master for setup
package modbus_pkg;
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  // 3.5 characters of 11 bits at 9600 baud
  localparam int GAP_NS = 4_010_416;
  localparam int GAP_CYCLES = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMEOUT_MS = 2000;
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [5:0] STATION_RST = 6'h1F;
  localparam logic [5:0] STATION_MAX = 6'h20;
  localparam logic [1:0] PARITY_RST = 2'h0;
  localparam logic [1:0] PARITY_BAD = 2'h3;
  localparam logic [6:0] DELAY_RST = 7'h05;
  localparam logic [6:0] DELAY_MIN = 7'h05;
  localparam logic [6:0] DELAY_MAX = 7'h41;
  localparam int STATION_LSB = 0;
  localparam int PARITY_LSB = 8;
  localparam int TMO_EN_BIT = 12;
  localparam int RTS_CTL_BIT = 16;
  localparam int DELAY_LSB = 24;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_LOOP = 8'h08;
  localparam logic [7:0] FN_WRITE = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [5:0] LEN_FIXED = 6'h08;
  localparam logic [5:0] LEN_WR_MIN = 6'h0B;
  localparam logic [5:0] LEN_MAX = 6'h29;
  localparam logic [5:0] LEN_EXC = 6'h05;
  localparam logic [5:0] LEN_MIN = 6'h04;
  localparam logic [5:0] RD_HDR = 6'h05;
  localparam logic [7:0] WR_HDR = 8'h09;
  localparam logic [15:0] QTY_MAX = 16'h0010;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  typedef enum logic [2:0] {IDLE, CHECK, EXEC, WAIT, PREP, LOAD, SEND} state_t;
endpackage

/* hdl/crc16_unit.sv */
// crc16_unit: byte-serial crc-16 register
// assumes bytes offered one per cycle on the same clock
`timescale 1ns/1ps
`default_nettype none
module crc16_unit import modbus_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  always_comb begin
    crc_d = crc_q ^ {8'h00, data};
    // reflected form: lsb of each byte first
    for (int i = 0; i < 8; i++) begin
      crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || init) begin
      crc_q <= CRC_INIT;
    end else if (en) begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
endmodule
`default_nettype wire

/* hdl/tick_timer.sv */
// tick_timer: saturating up counter with a done level
// assumes clr and en come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module tick_timer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic en,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] cnt_q;

  assign done = cnt_q >= limit;

  always_ff @(posedge clk) begin
    if (!resetn || clr) begin
      cnt_q <= '0;
    end else if (en && !done) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* testbench/modbus_master_model.sv */
// modbus_master_model: serial master on the slave's byte link
// assumes the slave clock; reply bytes are taken at accept edges
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
  input wire logic clk,
  output logic [7:0] rxByte,
  output logic rxValid,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  output logic txReady,
  input wire logic rtsOut
);
  logic [7:0] replyQ[$];
  logic slowMode;
  int rtsBad;
  int phase;
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b1;
    slowMode = 1'b0;
    rtsBad = 0;
    phase = 0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction
  // a reply whose check field disagrees is rejected
  function automatic logic crc_ok(input logic [7:0] r[$]);
    logic [7:0] body[$];
    if (r.size() < 4) return 1'b0;
    body = r[0:r.size()-3];
    return crc16(body) === {r[r.size()-1], r[r.size()-2]};
  endfunction
  // idle data line shows the inverse of the last byte, never a stale copy
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge clk);
      rxByte <= b[i];
      rxValid <= 1'b1;
      @(posedge clk);
      rxValid <= 1'b0;
      rxByte <= ~b[i];
    end
  endtask
  always @(posedge clk) begin
    phase <= phase + 1;
    txReady <= slowMode ? (phase % 3 == 0) : 1'b1;
    if (txValid === 1'b1 && txReady === 1'b1) begin
      replyQ.push_back(txByte);
      if (rtsOut !== 1'b1) rtsBad <= rtsBad + 1;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_modbus_slave.sv */
// tb_modbus_slave: frame level tests of the serial slave
// assumes shortened gap and millisecond counts; store answers addr xor a5c3
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_slave import modbus_pkg::*;;
  localparam int GAP = 20;
  localparam int MSL = 10;
  logic clk, resetn, hsel, hwrite, rxValid, txValid, txReady, rtsOut;
  logic hreadyout, hresp, commFault, regWrEn;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, parityMode;
  logic [2:0] hsize;
  logic [7:0] rxByte, txByte;
  logic [15:0] regWrAddr, regWrData, regRdAddr, regRdData;
  logic [31:0] wrQ[$];
  logic [7:0] c[$], e[$];
  int err_total, checks_done;
  modbus_slave #(.GAP_LEN(GAP), .MS_LEN(MSL)) modbus_slave_inst (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxByte(rxByte), .rxValid(rxValid),
    .txByte(txByte), .txValid(txValid), .txReady(txReady), .rtsOut(rtsOut), .parityMode(parityMode),
    .commFault(commFault), .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
    .regRdAddr(regRdAddr), .regRdData(regRdData));
  modbus_master_model modbus_master_model_inst (.clk(clk), .rxByte(rxByte), .rxValid(rxValid),
    .txByte(txByte), .txValid(txValid), .txReady(txReady), .rtsOut(rtsOut));
  assign regRdData = regRdAddr ^ 16'hA5C3;
  always @(posedge clk) if (regWrEn === 1'b1) wrQ.push_back({regWrAddr, regWrData});
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    hsel <= 1'b0;
  endtask
  function automatic void addcrc(ref logic [7:0] q[$]);
    logic [15:0] v;
    v = modbus_master_model_inst.crc16(q);
    q.push_back(v[7:0]);
    q.push_back(v[15:8]);
  endfunction
  // empty expectation means no reply may appear at all
  task automatic frame(input logic [7:0] cmd[$], input logic [7:0] exp[$]);
    modbus_master_model_inst.replyQ.delete();
    modbus_master_model_inst.send(cmd);
    repeat (5 * MSL) @(posedge clk);
    check_eq(modbus_master_model_inst.replyQ.size(), 0);
    for (int n = 0; n < 1500; n++) begin
      @(posedge clk);
      if (n > 200 && modbus_master_model_inst.replyQ.size() >= exp.size()) break;
    end
    check_eq(modbus_master_model_inst.replyQ.size(), exp.size());
    foreach (exp[i]) if (i < modbus_master_model_inst.replyQ.size())
      check_eq(modbus_master_model_inst.replyQ[i], exp[i]);
    if (exp.size() > 0) check_eq(modbus_master_model_inst.crc_ok(modbus_master_model_inst.replyQ), 1);
    check_eq(modbus_master_model_inst.rtsBad, 0);
    check_eq(rtsOut, 1'b0);
  endtask
  task automatic test_config();
    ahb(0, CFG_OFS, 0, r);
    check_eq(r, 32'h0501_101F);
    check_eq(hresp, 1'b0);
    ahb(1, CFG_OFS, 32'h0501_1201, r);
    ahb(0, CFG_OFS, 0, r);
    check_eq(r, 32'h0501_1201);
    check_eq(parityMode, 2'h2);
    ahb(1, CFG_OFS, 32'h0501_1121, r);
    ahb(0, CFG_OFS, 0, r);
    check_eq(r, 32'h0501_1101);
    check_eq(parityMode, 2'h1);
    ahb(0, 32'h0000_0008, 0, r);
    check_eq(r, 32'h0000_0000);
  endtask
  task automatic test_loop();
    c = '{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37, 8'hDA, 8'h8D};
    frame(c, c);
    modbus_master_model_inst.slowMode = 1'b1;
    c = '{8'h01, 8'h08, 8'hFF, 8'hFF, 8'h12, 8'h34};
    addcrc(c);
    frame(c, c);
    modbus_master_model_inst.slowMode = 1'b0;
  endtask
  task automatic test_write();
    wrQ.delete();
    c = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h02, 8'h58, 8'h63, 8'h39};
    e = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h10, 8'h08};
    frame(c, e);
    check_eq(wrQ.size(), 2);
    check_eq(wrQ[0], 32'h0001_0001);
    check_eq(wrQ[1], 32'h0002_0258);
  endtask
  task automatic test_read();
    logic [15:0] v;
    c = '{8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h10};
    addcrc(c);
    e = '{8'h01, 8'h03, 8'h20};
    for (int i = 0; i < 16; i++) begin
      v = (16'h0100 + 16'(i)) ^ 16'hA5C3;
      e.push_back(v[15:8]);
      e.push_back(v[7:0]);
    end
    addcrc(e);
    frame(c, e);
  endtask
  task automatic test_errors();
    c = '{8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
    addcrc(c);
    e = '{8'h01, 8'h87, 8'h01};
    addcrc(e);
    frame(c, e);
    c = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h11};
    addcrc(c);
    e = '{8'h01, 8'h83, 8'h03};
    addcrc(e);
    frame(c, e);
    c = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01};
    addcrc(c);
    e = '{8'h01, 8'h90, 8'h03};
    addcrc(e);
    frame(c, e);
  endtask
  task automatic test_drops();
    wrQ.delete();
    e.delete();
    c = '{8'h00, 8'h10, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
    addcrc(c);
    frame(c, e);
    check_eq(wrQ.size(), 1);
    check_eq(wrQ[0], 32'h0005_1234);
    frame('{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37, 8'hDA, 8'h8C}, e);
    frame('{8'h02, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37, 8'hDA, 8'h8D}, e);
  endtask
  task automatic test_timeout();
    c = '{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37, 8'hDA, 8'h8D};
    frame(c, c);
    repeat (19000) @(posedge clk);
    check_eq(commFault, 1'b0);
    repeat (1500) @(posedge clk);
    check_eq(commFault, 1'b1);
    ahb(0, STAT_OFS, 0, r);
    check_eq(r[0], 1'b1);
    // timeout check and send request control both switched off
    ahb(1, CFG_OFS, 32'h0500_0101, r);
    repeat (3) @(posedge clk);
    check_eq(commFault, 1'b0);
    check_eq(rtsOut, 1'b1);
  endtask
  initial begin
    err_total = 0;
    checks_done = 0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    test_config();
    test_loop();
    test_write();
    test_read();
    test_errors();
    test_drops();
    test_timeout();
    test_done();
  end
  initial begin
    #600_000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
